// [rtl/tccc_pkg.sv]
package tccc_pkg;

    // ****************************************
    // Widths and counts
    // ****************************************
    localparam int TCCC_NCH = 4;
    localparam int TCCC_CW = 16;
    localparam int TCCC_FLTW = 4;

    // ****************************************
    // Source select codes
    // ****************************************
    localparam logic [1:0] TCCC_MS_OUT = 2'h0;
    localparam logic [1:0] TCCC_MS_OWN = 2'h1;
    localparam logic [1:0] TCCC_MS_PAIR = 2'h2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] TCCC_CV_RST = 16'h0000;
    localparam logic TCCC_PREP_RST = 1'b0;

    typedef enum logic [2:0] {
        TCCC_CM_FROZEN = 3'b000,
        TCCC_CM_SET = 3'b001,
        TCCC_CM_CLR = 3'b010,
        TCCC_CM_TOG = 3'b011,
        TCCC_CM_FLO = 3'b100,
        TCCC_CM_FHI = 3'b101,
        TCCC_CM_PWM0 = 3'b110,
        TCCC_CM_PWM1 = 3'b111
    } tccc_cmode_t;

    // Per-channel static configuration
    typedef struct packed {
        logic [1:0] capture_source_select;
        logic channel_polarity;
        logic complement_polarity;
        logic [3:0] capture_filter_cfg;
        logic [1:0] capture_prescale;
        logic channel_output_enable;
        tccc_cmode_t compare_mode_field;
        logic compare_shadow_enable;
        logic trigger_clear_enable;
        logic channel_irq_enable;
        logic channel_dma_enable;
        logic compare_dma_enable;
    } tccc_chcfg_t;

    // Counter unit view
    typedef struct packed {
        logic [15:0] count;
        logic down;
        logic center;
        logic [15:0] reload;
        logic update;
    } tccc_cnt_t;

endpackage : tccc_pkg

// [rtl/tccc_channels.sv]
`timescale 1ns/1ps
// Functional notes
// - Capture edge latches counter, sets flag, irq
// - Input is own pin; channel 0 may take XOR of pins 0-2
// - Synchronise, filter, detect both edges
// - Polarity picks rising or falling edge
// - Prescaler divides qualifying capture events
// - Input mode blocks software value writes
// - Capture over set flag sets overcapture
// - Irq and DMA only when enabled
// - Soft generate produces channel event
// - Code 01 own input, 10 neighbour input
// - Compare match sets, clears or toggles output
// - Match sets flag, irq, compare DMA
// - Shadow enable buffers compare value writes
// - Codes 110/111 generate PWM
// - Edge-aligned: period reload, duty value
// - Center-aligned: period and duty doubled
// - PWM0 value above reload: always active
// - PWM0 value zero: always inactive
// - Match codes keep, set, clear, toggle
// - Codes 4/5 force inactive/active
// - PWM level from direction and compare
// - Trigger clear holds prepare low until update
module tccc_channels
    import tccc_pkg::*;
#(
    parameter int NCH = TCCC_NCH,
    parameter int CW = TCCC_CW
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Counter unit
    input wire tccc_cnt_t CNT,
    // Pins and trigger
    input wire logic [NCH-1:0] CH_PIN,
    input wire logic XOR_SEL,
    input wire logic FILTERED_EXTERNAL_TRIGGER,
    // Configuration and software access
    input wire tccc_chcfg_t [NCH-1:0] CFG,
    input wire logic [NCH-1:0] CV_WR,
    input wire logic [CW-1:0] CV_WDATA,
    input wire logic [NCH-1:0] CHANNEL_SOFT_GENERATE,
    input wire logic [NCH-1:0] FLAG_CLR,
    input wire logic [NCH-1:0] OVF_CLR,
    // Results
    output logic [NCH-1:0][CW-1:0] CHANNEL_VALUE_REG,
    output logic [NCH-1:0] CHANNEL_EVENT_FLAG,
    output logic [NCH-1:0] CHANNEL_OVERCAPTURE_FLAG,
    output logic [NCH-1:0] CH_IRQ,
    output logic [NCH-1:0] CH_DMA_REQ,
    output logic [NCH-1:0] OUTPUT_PREPARE_SIGNAL,
    output logic [NCH-1:0] CH_OUT
);

    // ****************************************
    // Channel input selection
    // ****************************************
    logic xor3;
    logic [NCH-1:0] channel_input_signal;
    logic [NCH-1:0] filt;
    logic [NCH-1:0] filt_prev;
    assign xor3 = CH_PIN[0] ^ CH_PIN[1] ^ CH_PIN[2];

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            localparam int PAIR = g ^ 1;
            logic s1_q, s2_q, filt_q, filt_prev_q;
            logic [TCCC_FLTW-1:0] fcnt_q;
            logic [CW-1:0] cv_q, shadow_q;
            logic flag_q, ovf_q, irq_q, dma_q, prep_q, out_q, etr_hold_q;
            logic rise, fall, edge_sel, qual, cap, match, is_in, evt;
            logic [2:0] psc_lim;
            logic pwm0;

            assign channel_input_signal[g] = (XOR_SEL && g == 0) ? xor3 : CH_PIN[g];
            assign filt[g] = filt_q;
            assign filt_prev[g] = filt_prev_q;
            assign is_in = CFG[g].capture_source_select != TCCC_MS_OUT;

            // Two-stage synchroniser
            always_ff @(posedge CORE_CLK) begin : p_sync
                if (RST) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end else begin
                    s1_q <= channel_input_signal[g];
                    s2_q <= s1_q;
                end
            end

            // Filter: new level must hold for cfg+1 consecutive samples
            always_ff @(posedge CORE_CLK) begin : p_filt
                if (RST) begin
                    fcnt_q <= '0;
                    filt_q <= 1'b0;
                    filt_prev_q <= 1'b0;
                end else begin
                    filt_prev_q <= filt_q;
                    if (s2_q == filt_q) begin
                        fcnt_q <= '0;
                    end else if (fcnt_q >= CFG[g].capture_filter_cfg) begin
                        filt_q <= s2_q;
                        fcnt_q <= '0;
                    end else begin
                        fcnt_q <= fcnt_q + 1'b1;
                    end
                end
            end

            assign rise = filt_q & ~filt_prev_q;
            assign fall = ~filt_q & filt_prev_q;

            // ****************************************
            // Capture path
            // ****************************************
            always_comb begin
                edge_sel = CFG[g].channel_polarity ? fall : rise;
                unique case (CFG[g].capture_source_select)
                    TCCC_MS_OWN: qual = edge_sel;
                    TCCC_MS_PAIR: qual = CFG[g].channel_polarity ? (~filt[PAIR] & filt_prev[PAIR])
                                                                 : (filt[PAIR] & ~filt_prev[PAIR]);
                    default: qual = 1'b0;
                endcase
                qual = qual & CFG[g].channel_output_enable;
            end

            // Prescale 1, 2, 4 or 8 events per capture
            assign psc_lim = 3'((4'h1 << CFG[g].capture_prescale) - 4'h1);
            // Three bits so the divide-by-eight setting still wraps
            logic [2:0] pcnt_q;
            always_ff @(posedge CORE_CLK) begin : p_pcnt
                if (RST || !is_in) begin
                    pcnt_q <= '0;
                end else if (qual) begin
                    pcnt_q <= (pcnt_q == psc_lim) ? 3'h0 : pcnt_q + 3'h1;
                end
            end
            assign cap = is_in && qual && (pcnt_q == psc_lim);

            // ****************************************
            // Compare value and shadow
            // ****************************************
            always_ff @(posedge CORE_CLK) begin : p_cv
                if (RST) begin
                    cv_q <= TCCC_CV_RST;
                    shadow_q <= TCCC_CV_RST;
                end else if (cap) begin
                    cv_q <= CNT.count;
                end else if (!is_in) begin
                    if (CV_WR[g]) begin
                        shadow_q <= CV_WDATA;
                        if (!CFG[g].compare_shadow_enable) begin
                            cv_q <= CV_WDATA;
                        end
                    end else if (CFG[g].compare_shadow_enable && CNT.update) begin
                        cv_q <= shadow_q;
                    end
                end
                // Writes while is_in are dropped
            end

            assign match = !is_in && (CNT.count == cv_q);
            assign evt = cap || match || CHANNEL_SOFT_GENERATE[g];

            // Flags: set wins over clear
            always_ff @(posedge CORE_CLK) begin : p_flag
                if (RST) begin
                    flag_q <= 1'b0;
                    ovf_q <= 1'b0;
                    irq_q <= 1'b0;
                    dma_q <= 1'b0;
                end else begin
                    flag_q <= evt | (flag_q & ~FLAG_CLR[g]);
                    ovf_q <= (cap & flag_q) | (ovf_q & ~OVF_CLR[g]);
                    irq_q <= evt & CFG[g].channel_irq_enable;
                    dma_q <= evt & (is_in ? CFG[g].channel_dma_enable
                                          : (CFG[g].compare_dma_enable | CFG[g].channel_dma_enable));
                end
            end

            // ****************************************
            // Output prepare
            // ****************************************
            always_comb begin
                // Up: active below value; down: active at or below value
                if (cv_q == '0) begin
                    pwm0 = 1'b0;
                end else if (cv_q > CNT.reload) begin
                    pwm0 = 1'b1;
                end else begin
                    pwm0 = CNT.down ? (CNT.count <= cv_q) : (CNT.count < cv_q);
                end
            end

            always_ff @(posedge CORE_CLK) begin : p_etr
                if (RST) begin
                    etr_hold_q <= 1'b0;
                end else if (CFG[g].trigger_clear_enable && FILTERED_EXTERNAL_TRIGGER) begin
                    etr_hold_q <= 1'b1;
                end else if (CNT.update) begin
                    etr_hold_q <= 1'b0;
                end
            end

            always_ff @(posedge CORE_CLK) begin : p_prep
                if (RST) begin
                    prep_q <= TCCC_PREP_RST;
                end else if (etr_hold_q || (CFG[g].trigger_clear_enable && FILTERED_EXTERNAL_TRIGGER)) begin
                    prep_q <= 1'b0;
                end else begin
                    unique case (CFG[g].compare_mode_field)
                        TCCC_CM_FROZEN: prep_q <= prep_q;
                        TCCC_CM_SET: prep_q <= match ? 1'b1 : prep_q;
                        TCCC_CM_CLR: prep_q <= match ? 1'b0 : prep_q;
                        TCCC_CM_TOG: prep_q <= match ? ~prep_q : prep_q;
                        TCCC_CM_FLO: prep_q <= 1'b0;
                        TCCC_CM_FHI: prep_q <= 1'b1;
                        TCCC_CM_PWM0: prep_q <= pwm0;
                        TCCC_CM_PWM1: prep_q <= ~pwm0;
                    endcase
                end
            end

            // Pin level follows prepare one cycle later, polarity applied
            always_ff @(posedge CORE_CLK) begin : p_out
                if (RST) begin
                    out_q <= 1'b0;
                end else begin
                    out_q <= CFG[g].channel_output_enable && !is_in && (prep_q ^ CFG[g].channel_polarity);
                end
            end

            assign CHANNEL_VALUE_REG[g] = cv_q;
            assign CHANNEL_EVENT_FLAG[g] = flag_q;
            assign CHANNEL_OVERCAPTURE_FLAG[g] = ovf_q;
            assign CH_IRQ[g] = irq_q;
            assign CH_DMA_REQ[g] = dma_q;
            assign OUTPUT_PREPARE_SIGNAL[g] = prep_q;
            assign CH_OUT[g] = out_q;
        end
    endgenerate

endmodule : tccc_channels

// [tb/tccc_channels_properties.sv]
`timescale 1ns/1ps
module tccc_channels_properties
    import tccc_pkg::*;
#(parameter int NCH = TCCC_NCH, parameter int CW = TCCC_CW) (
    // Clock, reset and stimulus
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire tccc_cnt_t CNT,
    input wire logic FILTERED_EXTERNAL_TRIGGER,
    input wire tccc_chcfg_t [NCH-1:0] CFG,
    // Results
    input wire logic [NCH-1:0][CW-1:0] CHANNEL_VALUE_REG,
    input wire logic [NCH-1:0] CHANNEL_EVENT_FLAG,
    input wire logic [NCH-1:0] CHANNEL_OVERCAPTURE_FLAG,
    input wire logic [NCH-1:0] CH_IRQ,
    input wire logic [NCH-1:0] CH_DMA_REQ,
    input wire logic [NCH-1:0] OUTPUT_PREPARE_SIGNAL
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    wire tccc_cmode_t md = CFG[1].compare_mode_field;
    wire logic p1 = OUTPUT_PREPARE_SIGNAL[1];
    wire logic [15:0] v1 = CHANNEL_VALUE_REG[1];

    a_irq_gated: assert property (CH_IRQ[0] |-> CHANNEL_EVENT_FLAG[0] && $past(CFG[0].channel_irq_enable))
        else $error("irq without flag or enable");
    a_dma_gated: assert property (CH_DMA_REQ[1] |-> $past(CFG[1].compare_dma_enable | CFG[1].channel_dma_enable))
        else $error("dma request without enable");
    a_cv_guard: assert property (CFG[0].capture_source_select != TCCC_MS_OUT && $changed(CHANNEL_VALUE_REG[0]) |-> CH_IRQ[0])
        else $error("input channel value moved without a capture");
    a_ovf_cause: assert property ($rose(CHANNEL_OVERCAPTURE_FLAG[0]) |-> $past(CHANNEL_EVENT_FLAG[0]))
        else $error("overcapture without pending flag");
    a_force_low: assert property ((md == TCCC_CM_FLO) [*2] |-> !p1)
        else $error("forced low not low");
    a_force_high: assert property ((md == TCCC_CM_FHI && !CFG[1].trigger_clear_enable) [*2] |-> p1)
        else $error("forced high not high");
    a_toggle_match: assert property (CFG[1].capture_source_select == TCCC_MS_OUT && md == TCCC_CM_TOG && CNT.count == v1
        |=> $changed(p1) && CHANNEL_EVENT_FLAG[1]) else $error("match did not toggle and flag");
    a_pwm_zero: assert property ((md == TCCC_CM_PWM0 && v1 == 16'h0000 && !CNT.down) [*2] |-> !p1)
        else $error("pwm with zero value not inactive");
    a_pwm_full: assert property ((md == TCCC_CM_PWM0 && v1 > CNT.reload) [*2] |-> p1)
        else $error("pwm above reload not active");
    a_trig_clear: assert property (CFG[1].trigger_clear_enable && FILTERED_EXTERNAL_TRIGGER |=> !p1)
        else $error("trigger did not clear prepare");
endmodule : tccc_channels_properties

bind tccc_channels tccc_channels_properties #(.NCH(NCH), .CW(CW)) tccc_channels_properties_i (
    .CORE_CLK, .RST, .CNT, .FILTERED_EXTERNAL_TRIGGER, .CFG, .CHANNEL_VALUE_REG, .CHANNEL_EVENT_FLAG,
    .CHANNEL_OVERCAPTURE_FLAG, .CH_IRQ, .CH_DMA_REQ, .OUTPUT_PREPARE_SIGNAL);

// [tb/tccc_pulse_src.sv]
`timescale 1ns/1ps
module tccc_pulse_src (
    // Clock and request
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] width,
    // Pin
    output logic pin
);
    logic [7:0] left_q = 8'h00;
    logic go_s;
    initial pin = 1'b0;
    // Request sampled on the edge, pin moved just after it
    always @(posedge clk) begin
        go_s = go;
        #1;
        if (go_s) begin
            left_q = width;
            pin = 1'b1;
        end else if (left_q != 8'h00) begin
            left_q = left_q - 8'h01;
            pin = (left_q != 8'h00);
        end
    end
endmodule : tccc_pulse_src

// [tb/tccc_channels_tb.sv]
`timescale 1ns/1ps
module tccc_channels_tb;
    import tccc_pkg::*;
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    tccc_cnt_t cnt;
    tccc_chcfg_t [3:0] cfg;
    logic [3:1] pins_hi;
    logic [3:0] wr, gen, fclr, oclr, flag, ovf, irq, dma, prep, chout;
    logic xsel, trig, go, pin0, run;
    logic [15:0] wdata, hi;
    logic [3:0][15:0] cv;
    int n_fail = 0;
    int checked = 0;
    tccc_cmode_t md[6] = '{TCCC_CM_SET, TCCC_CM_FROZEN, TCCC_CM_CLR, TCCC_CM_FROZEN, TCCC_CM_FHI, TCCC_CM_FLO};
    logic [15:0] ex[6] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0001, 16'h0000};
    tccc_cmode_t pm[4] = '{TCCC_CM_PWM0, TCCC_CM_PWM1, TCCC_CM_PWM0, TCCC_CM_PWM0};
    logic [15:0] pv[4] = '{16'h0005, 16'h0005, 16'h0000, 16'h0020};
    logic [15:0] pe[4] = '{16'h0005, 16'h000F, 16'h0000, 16'h0014};

    always #12.5 CORE_CLK = ~CORE_CLK;

    tccc_pulse_src tccc_pulse_src_i (.clk(CORE_CLK), .go(go), .width(8'h10), .pin(pin0));
    tccc_channels tccc_channels_i (.CORE_CLK(CORE_CLK), .RST(RST), .CNT(cnt), .CH_PIN({pins_hi, pin0}),
        .XOR_SEL(xsel), .FILTERED_EXTERNAL_TRIGGER(trig), .CFG(cfg), .CV_WR(wr), .CV_WDATA(wdata),
        .CHANNEL_SOFT_GENERATE(gen), .FLAG_CLR(fclr), .OVF_CLR(oclr), .CHANNEL_VALUE_REG(cv),
        .CHANNEL_EVENT_FLAG(flag), .CHANNEL_OVERCAPTURE_FLAG(ovf), .CH_IRQ(irq), .CH_DMA_REQ(dma),
        .OUTPUT_PREPARE_SIGNAL(prep), .CH_OUT(chout));

    // Stand-in for the counter unit, edge or center aligned; flop-like so reads never race it
    always @(posedge CORE_CLK) begin
        cnt.update <= run && !cnt.center && (cnt.count == cnt.reload);
        if (run && !cnt.center) begin
            cnt.count <= (cnt.count == cnt.reload) ? 16'h0000 : cnt.count + 16'h0001;
        end else if (run) begin
            cnt.count <= cnt.down ? cnt.count - 16'h0001 : cnt.count + 16'h0001;
            cnt.down <= cnt.down ? (cnt.count != 16'h0001) : (cnt.count == cnt.reload - 16'h0001);
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (exp !== got) begin
            n_fail++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk

    task automatic wr_cv(input int ch, input logic [15:0] d);
        wdata = d;
        wr[ch] = 1'b1;
        tick(1);
        wr = 4'h0;
        tick(1);
    endtask : wr_cv

    // Waits long enough for rise, sync, filter and capture
    task automatic edge_in(input int n);
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(n);
    endtask : edge_in

    task automatic stop_test;
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    initial begin
        repeat (3000) @(posedge CORE_CLK);
        n_fail++;
        stop_test;
    end

    initial begin
        cfg = '0;
        cnt = '0;
        cnt.reload = 16'h0013;
        // Nonzero so output channels see no match at reset release
        cnt.count = 16'h1234;
        {pins_hi, wr, gen, fclr, oclr, xsel, trig, go, run, wdata} = '0;
        tick(12);
        RST = 1'b0;
        tick(1);
        cfg[0].capture_source_select = TCCC_MS_OWN;
        cfg[0].channel_irq_enable = 1'b1;
        cfg[0].channel_output_enable = 1'b1;
        cfg[1].capture_source_select = TCCC_MS_PAIR;
        cfg[1].channel_output_enable = 1'b1;
        edge_in(20);
        chk(16'h1234, cv[0]);
        chk(16'h1234, cv[1]);
        chk(16'(flag[0]), 16'h0001);
        chk(16'h0000, 16'(ovf[0]));
        cnt.count = 16'h0055;
        edge_in(10);
        cnt.count = 16'h0066;
        tick(20);
        chk(16'h0055, cv[0]);
        chk(16'(ovf[0]), 16'h0001);
        fclr = 4'h1;
        oclr = 4'h1;
        cfg[0].capture_prescale = 2'h1;
        cnt.count = 16'h00AA;
        tick(1);
        fclr = 4'h0;
        oclr = 4'h0;
        edge_in(30);
        chk(16'(flag[0]), 16'h0000);
        chk(16'h0000, 16'(ovf[0]));
        edge_in(30);
        chk(16'h00AA, cv[0]);
        wr_cv(0, 16'hBEEF);
        chk(16'h00AA, cv[0]);
        cfg[0].capture_prescale = 2'h0;
        cfg[0].channel_polarity = 1'b1;
        cnt.count = 16'h0077;
        edge_in(10);
        chk(16'h00AA, cv[0]);
        tick(20);
        chk(16'h0077, cv[0]);
        // XOR input with the filter set to four samples: a two-cycle glitch must not pass
        xsel = 1'b1;
        cfg[0].capture_filter_cfg = 4'h3;
        cnt.count = 16'h0099;
        pins_hi = 3'b001;
        tick(2);
        pins_hi = 3'b000;
        tick(10);
        chk(16'h0077, cv[0]);
        pins_hi = 3'b001;
        tick(10);
        pins_hi = 3'b000;
        tick(12);
        chk(16'h0099, cv[0]);
        xsel = 1'b0;
        cfg[0].capture_filter_cfg = 4'h0;
        cfg[2].channel_irq_enable = 1'b1;
        cfg[2].channel_dma_enable = 1'b1;
        gen = 4'h4;
        tick(1);
        gen = 4'h0;
        chk(16'h0001, 16'(irq[2]));
        chk(16'h0001, 16'(dma[2]));
        tick(3);
        chk(16'(flag[2]), 16'h0001);
        cfg[1] = '0;
        cfg[1].channel_output_enable = 1'b1;
        cfg[1].compare_dma_enable = 1'b1;
        cnt.count = 16'h0000;
        fclr = 4'h2;
        wr_cv(1, 16'h0005);
        fclr = 4'h0;
        chk(16'h0005, cv[1]);
        chk(16'h0000, 16'(flag[1]));
        run = 1'b1;
        cfg[1].compare_mode_field = TCCC_CM_TOG;
        tick(45);
        chk(16'(flag[1]), 16'h0001);
        while (cnt.count != 16'h0005)
            tick(1);
        tick(1);
        chk(16'h0001, 16'(dma[1]));
        chk(16'h0000, 16'(irq[1]));
        for (int i = 0; i < 6; i++) begin
            cfg[1].compare_mode_field = md[i];
            tick(41);
            chk(ex[i], 16'(prep[1]));
            chk(ex[i], 16'(chout[1]));
        end
        for (int j = 0; j < 4; j++) begin
            cfg[1].compare_mode_field = pm[j];
            wr_cv(1, pv[j]);
            tick(20);
            hi = 16'h0000;
            repeat (20) begin
                tick(1);
                hi = hi + 16'(prep[1]);
            end
            chk(pe[j], hi);
        end
        // Buffered write lands only at the next update
        cfg[1].compare_shadow_enable = 1'b1;
        while (cnt.count != 16'h0008)
            tick(1);
        wr_cv(1, 16'h0009);
        chk(16'h0020, cv[1]);
        tick(20);
        chk(16'h0009, cv[1]);
        cfg[1].compare_shadow_enable = 1'b0;
        // Center-aligned: period twice reload, active count twice the value
        cnt.center = 1'b1;
        cnt.down = 1'b0;
        cnt.count = 16'h0000;
        wr_cv(1, 16'h0005);
        tick(40);
        hi = 16'h0000;
        repeat (38) begin
            tick(1);
            hi = hi + 16'(prep[1]);
        end
        chk(16'h000A, hi);
        cnt.center = 1'b0;
        cnt.down = 1'b0;
        cnt.count = 16'h0000;
        cfg[1].compare_mode_field = TCCC_CM_FHI;
        cfg[1].trigger_clear_enable = 1'b1;
        tick(3);
        while (cnt.count != 16'h0003)
            tick(1);
        trig = 1'b1;
        tick(1);
        trig = 1'b0;
        tick(3);
        chk(16'h0000, 16'(prep[1]));
        tick(20);
        chk(16'h0001, 16'(prep[1]));
        stop_test;
    end
endmodule : tccc_channels_tb
